// *** core/lf_tick_divider.sv ***
// low-frequency tick divider: one-cycle enable pulse at about 32 kHz.
// assumes mclk_in at the rate given in the package.
`timescale 1ns/1ns
module lf_tick_divider
    import sleep_timer_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // tick enable
    output logic tick_out
);

    logic [DIV_W-1:0] div_count;
    wire div_wrap = (div_count == TICK_LAST);
    wire [DIV_W-1:0] next_div_count = div_wrap ? DIV_RESET : div_count + DIV_ONE;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_count <= DIV_RESET;
            tick_out <= 1'b0;
        end else begin
            div_count <= next_div_count;
            tick_out <= div_wrap;
        end
    end

endmodule // lf_tick_divider

// *** core/sleep_timer_pkg.sv ***
// package for the sleep wakeup timer: rates, byte addresses, field layout, reset values, carrier types.
// assumes a single 25 MHz system clock; the 32 kHz low-frequency rate is derived from it as an enable.
package sleep_timer_pkg;

    // clock rates and the divider that makes the low-frequency tick
    localparam int MCLK_HZ = 25_000_000;
    localparam int LF_CLK_HZ = 32_768;
    // rounds down, so the tick runs slightly fast against a true 32768 Hz source
    localparam int TICK_DIV = MCLK_HZ / LF_CLK_HZ;
    localparam int DIV_W = 10;
    localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;
    localparam logic [DIV_W-1:0] DIV_ONE = 10'h001;
    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_DIV - 1);

    // widths and byte lanes of the count and compare words
    localparam int COUNT_W = 24;
    localparam int BYTE_W = 8;
    localparam int LOW_LSB = 0;
    localparam int MID_LSB = 8;
    localparam int HIGH_LSB = 16;

    // register byte addresses
    localparam logic [7:0] ADDR_COUNT_COMPARE_LOW = 8'h95;
    localparam logic [7:0] ADDR_COUNT_COMPARE_MID = 8'h96;
    localparam logic [7:0] ADDR_COUNT_COMPARE_HIGH = 8'h97;

    // reset and step values
    localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 24'hffffff;
    localparam logic [COUNT_W-1:0] COMPARE_RESET = 24'h0fffff;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

    // one register access request per cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [BYTE_W-1:0] wdata;
    } sfr_req_t;

    // system power modes
    typedef enum logic [1:0] {
        power_mode_active,
        power_mode_one,
        power_mode_two,
        power_mode_three
    } power_mode_t;

endpackage

// *** core/sleep_wakeup_timer.sv ***
// sleep wakeup timer: 24-bit count that runs in every power mode but mode three, 24-bit compare, flag, dma trigger and wake pulse.
// assumes byte-wide register strobes synchronous to mclk_in and a power mode input from the power manager.
`timescale 1ns/1ns
module sleep_wakeup_timer
    import sleep_timer_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // register access
    input wire sfr_req_t sfr_req_in,
    output logic [BYTE_W-1:0] rd_data_out,
    // power manager
    input wire power_mode_t power_mode_in,
    output logic wake_out,
    // interrupt bits
    input wire logic sleep_compare_irq_enable_in,
    input wire logic sleep_compare_irq_flag_clear_in,
    output logic sleep_compare_irq_flag_out,
    output logic irq_out,
    // dma
    output logic dma_trigger_11_out
);

    logic lf_tick;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] compare;
    logic [BYTE_W-1:0] stage_mid;
    logic [BYTE_W-1:0] stage_high;
    logic [BYTE_W-1:0] snap_mid;
    logic [BYTE_W-1:0] snap_high;

    // the tick is an enable in the system clock domain, so the event is already aligned
    lf_tick_divider u_tick (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .tick_out(lf_tick)
    );

    // counting and compare
    wire counting = (power_mode_in != power_mode_three);
    wire count_step = lf_tick && counting;
    wire [COUNT_W-1:0] next_count = count + COUNT_ONE;
    // compare only on the step, so a match held over many cycles fires once
    wire match_now = count_step && (next_count == compare);
    wire sleeping = (power_mode_in == power_mode_one) || (power_mode_in == power_mode_two);

    // register decode
    wire hit_low_rd = sfr_req_in.rd && (sfr_req_in.addr == ADDR_COUNT_COMPARE_LOW);
    wire hit_mid_rd = sfr_req_in.rd && (sfr_req_in.addr == ADDR_COUNT_COMPARE_MID);
    wire hit_high_rd = sfr_req_in.rd && (sfr_req_in.addr == ADDR_COUNT_COMPARE_HIGH);
    wire hit_low_wr = sfr_req_in.wr && (sfr_req_in.addr == ADDR_COUNT_COMPARE_LOW);
    wire hit_mid_wr = sfr_req_in.wr && (sfr_req_in.addr == ADDR_COUNT_COMPARE_MID);
    wire hit_high_wr = sfr_req_in.wr && (sfr_req_in.addr == ADDR_COUNT_COMPARE_HIGH);

    wire [BYTE_W-1:0] count_low = count[LOW_LSB +: BYTE_W];
    wire [BYTE_W-1:0] count_mid = count[MID_LSB +: BYTE_W];
    wire [BYTE_W-1:0] count_high = count[HIGH_LSB +: BYTE_W];
    wire [BYTE_W-1:0] wdata = sfr_req_in.wdata;

    // unmapped reads return zero
    wire [BYTE_W-1:0] read_byte = hit_low_rd ? count_low :
                                  hit_mid_rd ? snap_mid :
                                  hit_high_rd ? snap_high : BYTE_RESET;
    wire [COUNT_W-1:0] commit_value = {stage_high, stage_mid, wdata};

    // hardware set wins over a clear in the same cycle
    wire next_flag = match_now ? 1'b1 :
                     sleep_compare_irq_flag_clear_in ? 1'b0 : sleep_compare_irq_flag_out;

    // no software path reaches the counter
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count <= COUNT_RESET;
        end else if (count_step) begin
            count <= next_count;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            compare <= COMPARE_RESET;
            stage_mid <= BYTE_RESET;
            stage_high <= BYTE_RESET;
        end else begin
            if (hit_mid_wr) begin
                stage_mid <= wdata;
            end
            if (hit_high_wr) begin
                stage_high <= wdata;
            end
            if (hit_low_wr) begin
                compare <= commit_value;
            end
        end
    end

    // upper bytes read zero until the first low-byte read takes a snapshot
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            snap_mid <= BYTE_RESET;
            snap_high <= BYTE_RESET;
            rd_data_out <= BYTE_RESET;
        end else begin
            if (hit_low_rd) begin
                snap_mid <= count_mid;
                snap_high <= count_high;
            end
            if (sfr_req_in.rd) begin
                rd_data_out <= read_byte;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sleep_compare_irq_flag_out <= 1'b0;
            irq_out <= 1'b0;
            dma_trigger_11_out <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            sleep_compare_irq_flag_out <= next_flag;
            irq_out <= next_flag && sleep_compare_irq_enable_in;
            dma_trigger_11_out <= match_now;
            wake_out <= match_now && sleeping;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    tick_single_a: assert property (lf_tick |=> !lf_tick)
        else $error("tick lasted more than one cycle");
    count_step_a: assert property (count_step |=> count == $past(next_count))
        else $error("count did not step on tick");
    count_hold_a: assert property (!count_step |=> $stable(count))
        else $error("count moved without a running tick");
    count_wrap_a: assert property (count_step && count == COUNT_MAX |=> count == COUNT_RESET)
        else $error("count did not wrap to zero");
    flag_set_a: assert property (match_now |=> sleep_compare_irq_flag_out)
        else $error("compare match did not set the flag");
    irq_gate_a: assert property (irq_out |-> $past(sleep_compare_irq_enable_in) && sleep_compare_irq_flag_out)
        else $error("interrupt raised while disabled");
    dma_once_a: assert property (dma_trigger_11_out |=> !dma_trigger_11_out [*2])
        else $error("dma trigger repeated for one match");
    dma_cause_a: assert property (match_now |=> dma_trigger_11_out)
        else $error("match did not drive the dma trigger");
    wake_cause_a: assert property (match_now && sleeping |=> wake_out)
        else $error("no wake on match in sleep mode");
    wake_gate_a: assert property (wake_out |-> $past(sleeping) && dma_trigger_11_out)
        else $error("wake outside a sleep mode");
    stage_hold_a: assert property ((hit_mid_wr || hit_high_wr) && !hit_low_wr |=> $stable(compare))
        else $error("staged write reached the compare value");
    compare_commit_a: assert property (hit_low_wr |=> compare == $past(commit_value))
        else $error("low write did not commit the compare value");
    low_read_a: assert property (hit_low_rd |=> rd_data_out == $past(count_low) && snap_mid == $past(count_mid))
        else $error("low read did not return live byte and snapshot");
    mid_read_a: assert property (hit_mid_rd |=> rd_data_out == $past(snap_mid))
        else $error("middle read did not return the snapshot");

    // register side
    high_read_a: assert property (hit_high_rd |=> rd_data_out == $past(snap_high))
        else $error("high read did not return the snapshot");
    unmapped_read_a: assert property (
        sfr_req_in.rd && !hit_low_rd && !hit_mid_rd && !hit_high_rd |=> rd_data_out == BYTE_RESET)
        else $error("unmapped read returned nonzero data");
    read_hold_a: assert property (!sfr_req_in.rd |=> $stable(rd_data_out))
        else $error("read data moved without a read");
    snap_high_a: assert property (hit_low_rd |=> snap_high == $past(count_high))
        else $error("low read did not snapshot the high byte");
    snap_hold_a: assert property (!hit_low_rd |=> $stable(snap_mid) && $stable(snap_high))
        else $error("snapshot moved without a low read");
    stage_mid_a: assert property (hit_mid_wr |=> stage_mid == $past(wdata))
        else $error("middle write not staged");
    stage_high_a: assert property (hit_high_wr |=> stage_high == $past(wdata))
        else $error("high write not staged");
    compare_hold_a: assert property (!hit_low_wr |=> $stable(compare))
        else $error("compare value moved without a low write");

    // count and events
    tick_gap_a: assert property (lf_tick |=> !lf_tick [*8])
        else $error("ticks closer than the divider allows");
    frozen_count_a: assert property (power_mode_in == power_mode_three |=> $stable(count))
        else $error("count moved in mode three");
    frozen_event_a: assert property (power_mode_in == power_mode_three |=> !dma_trigger_11_out)
        else $error("compare event in mode three");
    dma_source_a: assert property (dma_trigger_11_out |-> $past(match_now))
        else $error("dma trigger without a match");
    wake_quiet_a: assert property (power_mode_in == power_mode_active |=> !wake_out)
        else $error("wake pulse in active mode");

    // flag and interrupt
    flag_clear_a: assert property (
        sleep_compare_irq_flag_clear_in && !match_now |=> !sleep_compare_irq_flag_out)
        else $error("flag survived a clear");
    flag_set_wins_a: assert property (
        match_now && sleep_compare_irq_flag_clear_in |=> sleep_compare_irq_flag_out)
        else $error("clear beat a same-cycle match");
    flag_hold_a: assert property (
        !sleep_compare_irq_flag_clear_in && !match_now |=> $stable(sleep_compare_irq_flag_out))
        else $error("flag moved without match or clear");
    flag_rise_a: assert property ($rose(sleep_compare_irq_flag_out) |-> dma_trigger_11_out)
        else $error("flag rose without a compare event");
    irq_set_a: assert property (match_now && sleep_compare_irq_enable_in |=> irq_out)
        else $error("enabled match raised no interrupt");
    irq_off_a: assert property (!sleep_compare_irq_enable_in |=> !irq_out)
        else $error("interrupt while the enable was low");

endmodule // sleep_wakeup_timer

// *** testbench/tb_sleep_wakeup_timer.sv ***
// self-checking bench for the sleep wakeup timer: register reads and writes, compare event, freeze.
// assumes the design package and modules are compiled first; expectations come from the rules.
`timescale 1ns/1ns
module tb_sleep_wakeup_timer;
    import sleep_timer_pkg::*;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    sfr_req_t req = '0;
    power_mode_t mode = power_mode_active;
    logic en = 1'b0;
    logic clr = 1'b0;
    logic [BYTE_W-1:0] rd_data;
    logic wake, flag, irq, dma;
    logic [BYTE_W-1:0] v;
    logic [BYTE_W-1:0] w;
    int fails = 0;
    int n_checks = 0;
    int dma_n = 0;

    always #20 mclk_in = ~mclk_in;
    // counts trigger pulses so a repeated trigger for one match is seen
    always @(posedge mclk_in) if (dma === 1'b1) dma_n <= dma_n + 1;

    sleep_wakeup_timer DUT (.mclk_in(mclk_in), .nrst_in(nrst_in), .sfr_req_in(req), .rd_data_out(rd_data),
        .power_mode_in(mode), .wake_out(wake), .sleep_compare_irq_enable_in(en),
        .sleep_compare_irq_flag_clear_in(clr), .sleep_compare_irq_flag_out(flag), .irq_out(irq),
        .dma_trigger_11_out(dma));

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk_in);
        #1 req = '0;
    endtask

    // result sampled one edge after the taking edge, where it stands until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge mclk_in);
        #1 req = '0;
        @(posedge mclk_in);
        #1 d = rd_data;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the whole sequence needs well under 10000 cycles
    initial begin
        #(40 * 20000);
        fails++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge mclk_in);
        #1 nrst_in = 1'b1;
        rd(8'h96, v);
        chk("mid snapshot before low read", 24'h0, v);
        rd(8'h95, v);
        chk("low count at start", 24'h0, v);
        rd(8'ha0, v);
        chk("unmapped read", 24'h0, v);
        chk("flag after reset", 24'h0, flag);
        $display("test reset done");
        repeat (800) @(posedge mclk_in);
        rd(8'h95, v);
        chk("low count after one tick", 24'h1, v);
        rd(8'h96, v);
        chk("mid count snapshot", 24'h0, v);
        rd(8'h97, v);
        chk("high count snapshot", 24'h0, v);
        $display("test counting done");
        wr(8'h97, 8'h00);
        wr(8'h96, 8'h00);
        wr(8'h95, 8'h03);
        // staged only: a leak into the compare word would move the match far away
        wr(8'h96, 8'hff);
        en = 1'b1;
        mode = power_mode_one;
        for (int i = 0; i < 3000 && dma !== 1'b1; i++) @(posedge mclk_in) #1;
        chk("dma trigger at match", 24'h1, dma);
        chk("flag at match", 24'h1, flag);
        chk("irq enabled", 24'h1, irq);
        chk("wake in mode one", 24'h1, wake);
        @(posedge mclk_in) #1;
        chk("dma one cycle", 24'h0, dma);
        chk("wake one cycle", 24'h0, wake);
        chk("flag sticky", 24'h1, flag);
        rd(8'h95, v);
        chk("count equals compare", 24'h3, v);
        $display("test compare done");
        clr = 1'b1;
        @(posedge mclk_in) #1 clr = 1'b0;
        @(posedge mclk_in) #1;
        chk("flag cleared", 24'h0, flag);
        chk("irq cleared", 24'h0, irq);
        chk("single trigger", 24'h1, dma_n);
        $display("test clear done");
        mode = power_mode_three;
        rd(8'h95, v);
        repeat (1600) @(posedge mclk_in);
        rd(8'h95, w);
        chk("frozen in mode three", v, w);
        // new match three steps past the frozen count; the middle lane is rewritten to zero over the leak probe byte
        wr(8'h97, 8'h00);
        wr(8'h96, 8'h00);
        wr(8'h95, w + 8'h03);
        mode = power_mode_active;
        // the low byte must move once before a deep sleep is entered
        v = w;
        for (int i = 0; i < 400 && v === w; i++) rd(8'h95, v);
        chk("low byte moved before mode two", w + 8'h01, v);
        chk("no trigger without match", 24'h1, dma_n);
        mode = power_mode_two;
        for (int i = 0; i < 3000 && dma !== 1'b1; i++) @(posedge mclk_in) #1;
        chk("second trigger", 24'h1, dma);
        chk("wake in mode two", 24'h1, wake);
        rd(8'h95, v);
        chk("running in mode two", w + 8'h03, v);
        chk("two triggers in all", 24'h2, dma_n);
        $display("test power modes done");
        final_report();
    end
endmodule // tb_sleep_wakeup_timer
